// ### srbrc_top.sv
// Rail source selection, push-button timing, adapter watchdog and the
// open-drain interrupt pulse. Analogue comparator results arrive as
// synchronous levels; host writes and reads arrive as one-cycle pulses.
`timescale 1ns/10ps
`default_nettype none

// Functional notes
// [RULE_01] Default: input if valid, else battery
// [RULE_02] Battery-forced: battery powers rail above undervoltage
// [RULE_03] Forced write below undervoltage falls to default
// [RULE_04] Undervoltage during forced mode returns to default
// [RULE_05] Forced mode stops charging
// [RULE_06] Floating off: rail disconnected, aux regulator off
// [RULE_07] Pulled-down off: rail disconnected and pulled down
// [RULE_08] Off modes left only by write or reset
// [RULE_09] Regulation needs input in valid window
// [RULE_10] Timer durations latched while timer runs
// [RULE_11] First press expiry sets flag, pulses interrupt
// [RULE_12] Second press expiry sets flag, interrupt only
// [RULE_13] Flags cleared by read; re-interrupt after clear
// [RULE_14] Ship wake: always-on on, count first press
// [RULE_15] Early release returns to ship mode
// [RULE_16] Held button after wake suppresses press events
// [RULE_17] Valid input ends ship wake immediately
// [RULE_18] Long press runs configured action at once
// [RULE_19] Warning flag before long press expiry
// [RULE_20] No late change into power cycle; gated
// [RULE_21] Reset request power-cycles rail, always-on stays
// [RULE_22] Adapter watchdog forces reset after 14 s
// [RULE_23] Open-drain 128 us low pulses after valid start
// [RULE_24] Masked events never pulse, even after unmask
module srbrc_top
  import srbrc_pkg::*;
#(
  parameter int unsigned INT_PULSE_CYC = INT_PULSE_CYCLES,
  parameter int unsigned TICK_CYC      = TICK_CYCLES,
  parameter int unsigned WATCHDOG_CYC  = WATCHDOG_CYCLES,
  parameter int unsigned RESET_OFF_CYC = RESET_OFF_CYCLES
)(
  input  wire logic              core_clk_in,
  input  wire logic              reset_in,
  input  wire logic              input_valid_in,
  input  wire logic              input_uvlo_ok_in,
  input  wire logic              input_above_sleep_in,
  input  wire logic              input_ovp_in,
  input  wire logic              battery_above_uvlo_in,
  input  wire logic [1:0]        rail_source_select_in,
  input  wire logic              rail_source_write_in,
  input  wire logic              button_input_n_in,
  input  wire logic [TIME_W-1:0] first_press_time_in,
  input  wire logic [TIME_W-1:0] second_press_time_in,
  input  wire logic [TIME_W-1:0] long_press_time_in,
  input  wire logic [TIME_W-1:0] warning_lead_time_in,
  input  wire logic [1:0]        long_press_action_in,
  input  wire logic              reset_needs_input_power_in,
  input  wire logic              hardware_reset_request_in,
  input  wire logic              ship_mode_request_in,
  input  wire logic              adapter_watchdog_enable_in,
  input  wire logic              i2c_transaction_in,
  input  wire logic              flag_read_in,
  input  wire logic [2:0]        press_int_mask_in,
  input  wire logic              startup_valid_in,
  input  wire logic              startup_fault_in,
  output logic [1:0]             rail_mode_out,
  output logic                   rail_from_input_out,
  output logic                   rail_from_battery_out,
  output logic                   rail_pulldown_out,
  output logic                   regulation_enable_out,
  output logic                   aux_regulator_allow_out,
  output logic                   always_on_enable_out,
  output logic                   charge_inhibit_out,
  output logic                   ship_mode_out,
  output logic                   hardware_reset_request_active_out,
  output logic                   first_press_flag_out,
  output logic                   second_press_flag_out,
  output logic                   reset_warning_flag_out,
  output logic                   int_n_out,
  output logic                   int_oe_out
);

  // True on the tick in which a press counter steps onto its threshold
  function automatic logic hit(input logic [PRESS_W-1:0] cnt,
                               input logic [PRESS_W-1:0] thr);
    hit = (PRESS_W'(cnt + 1'b1) == thr);
  endfunction

  srbrc_pwr_e         state, next_state;       // Power state
  srbrc_src_e         mode, next_mode;         // Effective rail source
  logic [CNT_W-1:0]   tick_cnt, next_tick_cnt; // Millisecond prescaler
  logic [CNT_W-1:0]   off_cnt, next_off_cnt;   // Power cycle off time
  logic [CNT_W-1:0]   wd_cnt, next_wd_cnt;     // Watchdog count
  logic               wd_run, next_wd_run;     // Watchdog armed
  logic               vin_q;                   // Input valid, last cycle
  logic               press_q;                 // Button pressed, last cycle
  logic               armed, next_armed;       // Press events allowed
  logic               vin_lost, next_vin_lost; // Input dropped during press
  logic [PRESS_W-1:0] press_cnt, next_press_cnt;
  logic [PRESS_W-1:0] thr1, thr2, thrw, thrl;  // Latched thresholds
  logic [PRESS_W-1:0] next_thr1, next_thr2, next_thrw, next_thrl;
  logic [1:0]         act_lat, next_act_lat;   // Action seen at press start
  logic [2:0]         flags, next_flags;       // Warning, second, first
  logic [2:0]         set_ev;                  // Flag set events
  logic               next_from_in, next_from_bat, next_pd, next_reg, next_aux;
  logic               press, tick, step, lp_hit;
  logic [1:0]         act_eff;                 // Action applied at expiry

  assign press = !button_input_n_in;
  assign tick  = (tick_cnt == CNT_W'(TICK_CYC - 1));
  assign step  = press && press_q && tick;

  // Late change of action to power cycle keeps the latched action
  always_comb
  begin
    act_eff = long_press_action_in;
    if (long_press_action_in == LP_POWER_CYCLE && act_lat != LP_POWER_CYCLE)
    begin
      act_eff = act_lat; // see [RULE_20]
    end
  end

  assign lp_hit = step && armed && state == PWR_ACTIVE && hit(press_cnt, thrl);

  // Next state for power, mode, button timing and watchdog
  always_comb
  begin
    next_state     = state;
    next_mode      = mode;
    next_tick_cnt  = tick ? '0 : CNT_W'(tick_cnt + 1'b1);
    next_off_cnt   = '0;
    next_wd_cnt    = CNT_W'(wd_cnt + 1'b1);
    next_wd_run    = wd_run;
    next_armed     = armed;
    next_vin_lost  = vin_lost || !input_valid_in;
    next_press_cnt = press_cnt;
    next_thr1      = thr1;
    next_thr2      = thr2;
    next_thrw      = thrw;
    next_thrl      = thrl;
    next_act_lat   = act_lat;
    next_flags     = flags;
    set_ev         = '0;
    // Durations latched only when a press starts
    if (press && !press_q)
    begin
      next_press_cnt = '0;                                    // see [RULE_10]
      next_thr1      = PRESS_W'(first_press_time_in);
      next_thr2      = PRESS_W'(first_press_time_in) + PRESS_W'(second_press_time_in);
      next_thrl      = PRESS_W'(long_press_time_in);
      next_thrw      = PRESS_W'(long_press_time_in) - PRESS_W'(warning_lead_time_in);
      next_act_lat   = long_press_action_in;
      next_vin_lost  = !input_valid_in;
    end
    else if (step && press_cnt != '1)
    begin
      next_press_cnt = PRESS_W'(press_cnt + 1'b1);
    end
    // Release re-arms press events
    if (!press)
    begin
      next_armed = 1'b1; // see [RULE_16]
    end
    // Flag events only when clear, armed and running
    if (step && armed && state == PWR_ACTIVE)
    begin
      set_ev[0] = hit(press_cnt, thr1) && !flags[0]; // see [RULE_11]
      set_ev[1] = hit(press_cnt, thr2) && !flags[1]; // see [RULE_12]
      set_ev[2] = hit(press_cnt, thrw) && !flags[2]; // see [RULE_19]
    end
    // Read clears, a same-cycle set wins
    next_flags = (flag_read_in ? 3'h0 : flags) | set_ev; // see [RULE_13]
    // Rail source writes and battery undervoltage fallback
    if (rail_source_write_in)
    begin
      next_mode = srbrc_src_e'(rail_source_select_in); // see [RULE_08]
      if (next_mode == SRC_BATTERY && !battery_above_uvlo_in)
      begin
        next_mode = SRC_NORMAL; // see [RULE_03]
      end
    end
    else if (mode == SRC_BATTERY && !battery_above_uvlo_in)
    begin
      next_mode = SRC_NORMAL; // see [RULE_04]
    end
    // Adapter watchdog starts when a valid adapter appears
    if (!adapter_watchdog_enable_in || !input_valid_in || i2c_transaction_in)
    begin
      next_wd_run = 1'b0; // see [RULE_22]
    end
    else if (input_valid_in && !vin_q)
    begin
      next_wd_run = 1'b1;
      next_wd_cnt = '0;
    end
    case (state)
      PWR_ACTIVE:
      begin
        if (hardware_reset_request_in ||
            (wd_run && wd_cnt == CNT_W'(WATCHDOG_CYC - 1)))
        begin
          next_state  = PWR_RESET; // see [RULE_21]
          next_wd_run = 1'b0;
        end
        else if (lp_hit && act_eff[LP_SHIP_BIT])
        begin
          next_state = PWR_SHIP; // see [RULE_18]
        end
        else if (lp_hit && act_eff == LP_POWER_CYCLE &&
                 !(reset_needs_input_power_in && next_vin_lost))
        begin
          next_state = PWR_RESET; // see [RULE_20]
        end
        else if (ship_mode_request_in)
        begin
          next_state = PWR_SHIP;
        end
      end
      PWR_SHIP:
      begin
        if (input_valid_in)
        begin
          next_state = PWR_ACTIVE; // see [RULE_17]
        end
        else if (press)
        begin
          next_state = PWR_WAKE; // see [RULE_14]
        end
      end
      PWR_WAKE:
      begin
        if (input_valid_in)
        begin
          next_state = PWR_ACTIVE; // see [RULE_17]
        end
        else if (!press)
        begin
          next_state = PWR_SHIP; // see [RULE_15]
        end
        else if (step && hit(press_cnt, thr1))
        begin
          next_state = PWR_ACTIVE; // see [RULE_14]
          next_armed = 1'b0;       // see [RULE_16]
        end
      end
      PWR_RESET:
      begin
        next_off_cnt = CNT_W'(off_cnt + 1'b1);
        next_mode    = SRC_NORMAL; // see [RULE_08]
        if (off_cnt == CNT_W'(RESET_OFF_CYC - 1))
        begin
          next_state = PWR_ACTIVE;
        end
      end
      default:
      begin
        next_state = PWR_ACTIVE;
      end
    endcase
  end

  // Rail switches from the current state and mode
  always_comb
  begin
    next_from_in  = 1'b0;
    next_from_bat = 1'b0;
    next_pd       = 1'b0;
    next_aux      = 1'b0;
    if (state == PWR_SHIP || state == PWR_WAKE || state == PWR_RESET)
    begin
      next_pd = 1'b1; // see [RULE_01]
    end
    else if (mode == SRC_NORMAL)
    begin
      next_from_in  = input_valid_in;  // see [RULE_01]
      next_from_bat = !input_valid_in;
      next_aux      = 1'b1;
    end
    else if (mode == SRC_BATTERY)
    begin
      next_from_bat = battery_above_uvlo_in; // see [RULE_02]
      next_aux      = 1'b1;
    end
    else
    begin
      next_pd = (mode == SRC_OFF_PULLDOWN); // see [RULE_06] see [RULE_07]
    end
    // Regulation only with input in its window and routed to the rail
    next_reg = next_from_in && input_uvlo_ok_in && input_above_sleep_in &&
               !input_ovp_in; // see [RULE_09]
  end

  // Register control state and the rail switch outputs
  always_ff @(posedge core_clk_in)
  begin
    if (reset_in)
    begin
      state                   <= PWR_ACTIVE;
      mode                    <= SRC_NORMAL;
      tick_cnt                <= '0;
      off_cnt                 <= '0;
      wd_cnt                  <= '0;
      wd_run                  <= 1'b0;
      vin_q                   <= 1'b0;
      press_q                 <= 1'b0;
      armed                   <= 1'b0;
      vin_lost                <= 1'b0;
      press_cnt               <= '0;
      thr1                    <= '0;
      thr2                    <= '0;
      thrw                    <= '0;
      thrl                    <= '0;
      act_lat                 <= LP_POWER_CYCLE;
      flags                   <= '0;
      rail_from_input_out     <= 1'b0;
      rail_from_battery_out   <= 1'b0;
      rail_pulldown_out       <= 1'b1;
      regulation_enable_out   <= 1'b0;
      aux_regulator_allow_out <= 1'b0;
    end
    else
    begin
      state                   <= next_state;
      mode                    <= next_mode;
      tick_cnt                <= next_tick_cnt;
      off_cnt                 <= next_off_cnt;
      wd_cnt                  <= next_wd_cnt;
      wd_run                  <= next_wd_run;
      vin_q                   <= input_valid_in;
      press_q                 <= press;
      armed                   <= next_armed;
      vin_lost                <= next_vin_lost;
      press_cnt               <= next_press_cnt;
      thr1                    <= next_thr1;
      thr2                    <= next_thr2;
      thrw                    <= next_thrw;
      thrl                    <= next_thrl;
      act_lat                 <= next_act_lat;
      flags                   <= next_flags;
      rail_from_input_out     <= next_from_in;
      rail_from_battery_out   <= next_from_bat;
      rail_pulldown_out       <= next_pd;
      regulation_enable_out   <= next_reg;
      aux_regulator_allow_out <= next_aux;
    end
  end

  assign rail_mode_out          = mode;
  assign charge_inhibit_out     = (mode == SRC_BATTERY); // see [RULE_05]
  assign always_on_enable_out   = (state != PWR_SHIP);   // see [RULE_21]
  assign ship_mode_out          = (state == PWR_SHIP);
  assign hardware_reset_request_active_out    = (state == PWR_RESET);
  assign first_press_flag_out   = flags[0];
  assign second_press_flag_out  = flags[1];
  assign reset_warning_flag_out = flags[2];

  // Interrupt pulses; up to three events queue during a pulse, further ones are dropped
  logic [CNT_W-1:0] pulse_cnt, next_pulse_cnt;
  logic [1:0]       pend, next_pend;
  logic             pulsing, next_pulsing;
  logic             int_ev;

  // Edges only: unmasking a standing condition makes no pulse
  assign int_ev = |(set_ev & ~press_int_mask_in) &&
                  startup_valid_in && !startup_fault_in; // see [RULE_24] see [RULE_23]

  always_comb
  begin
    next_pulse_cnt = '0;
    next_pulsing   = pulsing;
    next_pend      = pend;
    if (int_ev && pend != PEND_MAX)
    begin
      next_pend = 2'(pend + 1'b1);
    end
    if (pulsing)
    begin
      next_pulse_cnt = CNT_W'(pulse_cnt + 1'b1);
      if (pulse_cnt == CNT_W'(INT_PULSE_CYC - 1))
      begin
        next_pulsing = 1'b0; // see [RULE_23]
      end
    end
    else if (pend != 2'h0)
    begin
      next_pulsing = 1'b1;
      next_pend    = 2'(next_pend - 1'b1);
    end
  end

  always_ff @(posedge core_clk_in)
  begin
    if (reset_in)
    begin
      pulse_cnt  <= '0;
      pend       <= '0;
      pulsing    <= 1'b0;
      int_oe_out <= 1'b0;
    end
    else
    begin
      pulse_cnt  <= next_pulse_cnt;
      pend       <= next_pend;
      pulsing    <= next_pulsing;
      int_oe_out <= next_pulsing;
    end
  end

  // Open drain: only ever drives low
  assign int_n_out = 1'b0;

  // Helper: length of the current low pulse
  logic [CNT_W-1:0] oe_len;
  always_ff @(posedge core_clk_in)
  begin
    oe_len <= (reset_in || !int_oe_out) ? '0 : CNT_W'(oe_len + 1'b1);
  end

  property p_force_ignored;
    @(posedge core_clk_in) disable iff (reset_in)
    rail_source_write_in && rail_source_select_in == SRC_BATTERY &&
    !battery_above_uvlo_in && state != PWR_RESET |=> mode == SRC_NORMAL;
  endproperty
  a_force_ignored: assert property (p_force_ignored) // see [RULE_03]
    else $error("forced battery accepted below undervoltage");

  property p_auto_return;
    @(posedge core_clk_in) disable iff (reset_in)
    mode == SRC_BATTERY && !battery_above_uvlo_in && !rail_source_write_in |=>
      mode == SRC_NORMAL;
  endproperty
  a_auto_return: assert property (p_auto_return) // see [RULE_04]
    else $error("forced battery kept below undervoltage");

  property p_off_hold;
    @(posedge core_clk_in) disable iff (reset_in)
    mode[1] && !rail_source_write_in && state != PWR_RESET |=> $stable(mode);
  endproperty
  a_off_hold: assert property (p_off_hold) // see [RULE_08]
    else $error("rail off mode left without write or reset");

  property p_pulldown;
    @(posedge core_clk_in) disable iff (reset_in)
    mode == SRC_OFF_PULLDOWN && state == PWR_ACTIVE |=>
      rail_pulldown_out && !rail_from_input_out && !rail_from_battery_out;
  endproperty
  a_pulldown: assert property (p_pulldown) // see [RULE_07]
    else $error("pulled down mode not applied");

  property p_reg_window;
    @(posedge core_clk_in) disable iff (reset_in)
    regulation_enable_out |->
      $past(input_uvlo_ok_in && input_above_sleep_in && !input_ovp_in);
  endproperty
  a_reg_window: assert property (p_reg_window) // see [RULE_09]
    else $error("regulation outside input window");

  property p_pulse_width;
    @(posedge core_clk_in) disable iff (reset_in)
    $fell(int_oe_out) |-> $past(oe_len) == CNT_W'(INT_PULSE_CYC - 1);
  endproperty
  a_pulse_width: assert property (p_pulse_width) // see [RULE_23]
    else $error("interrupt pulse width wrong");

  property p_flag_held;
    @(posedge core_clk_in) disable iff (reset_in)
    first_press_flag_out && !flag_read_in |=> first_press_flag_out;
  endproperty
  a_flag_held: assert property (p_flag_held) // see [RULE_13]
    else $error("press flag cleared without read");

  property p_early_release;
    @(posedge core_clk_in) disable iff (reset_in)
    state == PWR_WAKE && !press && !input_valid_in |=> state == PWR_SHIP ##1 rail_pulldown_out;
  endproperty
  a_early_release: assert property (p_early_release) // see [RULE_15]
    else $error("early release did not return to ship");

  property p_vin_wake;
    @(posedge core_clk_in) disable iff (reset_in)
    state == PWR_WAKE && input_valid_in |=> state == PWR_ACTIVE;
  endproperty
  a_vin_wake: assert property (p_vin_wake) // see [RULE_17]
    else $error("valid input did not end ship wake");

  property p_hw_request;
    @(posedge core_clk_in) disable iff (reset_in)
    hardware_reset_request_in && state == PWR_ACTIVE |=>
      hardware_reset_request_active_out && always_on_enable_out ##1 rail_pulldown_out;
  endproperty
  a_hw_request: assert property (p_hw_request) // see [RULE_21]
    else $error("reset request did not power cycle");

endmodule

`default_nettype wire

// ### srbrc_pkg.sv
// Constants and types for the rail source, button and reset control block.
// Assumes one 125 MHz core clock; all timing counts derive from it.
package srbrc_pkg;
  localparam int CLK_FREQ_MHZ      = 125;              // Core clock rate
  localparam int INT_PULSE_TIME_US = 128;              // Interrupt pulse width
  localparam int INT_PULSE_CYCLES  = INT_PULSE_TIME_US * CLK_FREQ_MHZ;
  localparam int TICK_TIME_US      = 1000;             // Button timer unit, 1 ms
  localparam int TICK_CYCLES       = TICK_TIME_US * CLK_FREQ_MHZ;
  localparam int WATCHDOG_TIME_S   = 14;               // Adapter watchdog window
  localparam int WATCHDOG_CYCLES   = WATCHDOG_TIME_S * 1000000 * CLK_FREQ_MHZ;
  localparam int RESET_OFF_TIME_US = 1000;             // Rail off time in a power cycle
  localparam int RESET_OFF_CYCLES  = RESET_OFF_TIME_US * CLK_FREQ_MHZ;
  localparam int CNT_W             = 32;               // Long counter width
  localparam int TIME_W            = 8;                // Timer setting width, ms
  localparam int PRESS_W           = 10;               // Press length counter width
  localparam int LP_SHIP_BIT       = 1;                // Action codes 1x mean ship
  localparam logic [1:0] LP_POWER_CYCLE = 2'h0;        // Long press: power cycle
  localparam logic [1:0] PEND_MAX       = 2'h3;        // Queued interrupt limit

  // Rail source selection codes
  typedef enum logic [1:0] {
    SRC_NORMAL       = 2'b00,
    SRC_BATTERY      = 2'b01,
    SRC_OFF_FLOAT    = 2'b10,
    SRC_OFF_PULLDOWN = 2'b11
  } srbrc_src_e;

  // Power states
  typedef enum logic [1:0] {
    PWR_ACTIVE = 2'b00,
    PWR_SHIP   = 2'b01,
    PWR_WAKE   = 2'b10,
    PWR_RESET  = 2'b11
  } srbrc_pwr_e;
endpackage

// ### srbrc_partner.sv
// Far-side model: push-button with pull-up, and the host's interrupt watcher.
// Assumes the bench requests presses; sees the open-drain pin as value and enable.
`timescale 1ns/10ps
`default_nettype none
module srbrc_partner (
  input  wire logic clk_in,
  input  wire logic press_in,
  input  wire logic int_n_in,
  input  wire logic int_oe_in,
  output var logic  button_n_out,
  output var int    pulses_out,
  output var int    width_out
);
  logic int_wire;  // Pin level with the board pull-up
  int   run;       // Low cycles of the current pulse
  // Released pin floats up to the pull-up
  assign int_wire = int_oe_in ? int_n_in : 1'b1;
  initial
  begin
    button_n_out = 1'b1;
    pulses_out   = 0;
    width_out    = 0;
    run          = 0;
  end
  // Button moves just after the edge; pulses measured in whole cycles
  always @(posedge clk_in)
  begin
    button_n_out <= ~press_in;
    if (!int_wire)
      run <= run + 1;
    else if (run != 0)
    begin
      pulses_out <= pulses_out + 1;
      width_out  <= run;
      run        <= 0;
    end
  end
endmodule
`default_nettype wire

// ### srbrc_top_bench.sv
// Self-checking bench for the rail, button, watchdog and interrupt block.
// Assumes shortened timing parameters; the partner plays button and host.
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin fail_count++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module srbrc_top_bench;
  logic core_clk_in, reset_in, input_valid_in, input_uvlo_ok_in, input_above_sleep_in;
  logic input_ovp_in, battery_above_uvlo_in, rail_source_write_in, button_input_n_in;
  logic reset_needs_input_power_in, hardware_reset_request_in, ship_mode_request_in;
  logic adapter_watchdog_enable_in, i2c_transaction_in, flag_read_in;
  logic startup_valid_in, startup_fault_in, press_req;
  logic [1:0] rail_source_select_in, long_press_action_in, rail_mode_out;
  logic [7:0] first_press_time_in, second_press_time_in, long_press_time_in;
  logic [7:0] warning_lead_time_in;
  logic [2:0] press_int_mask_in;
  logic rail_from_input_out, rail_from_battery_out, rail_pulldown_out, regulation_enable_out;
  logic aux_regulator_allow_out, always_on_enable_out, charge_inhibit_out, ship_mode_out;
  logic hardware_reset_request_active_out, first_press_flag_out, second_press_flag_out;
  logic reset_warning_flag_out, int_n_out, int_oe_out;
  int   fail_count, num_checks, pulses, width, p0, code, exp;
  // Short counts keep the run brief
  srbrc_top #(.INT_PULSE_CYC(8), .TICK_CYC(4), .WATCHDOG_CYC(100), .RESET_OFF_CYC(10)) DUT (.*);
  srbrc_partner PEER (.clk_in(core_clk_in), .press_in(press_req), .int_n_in(int_n_out),
    .int_oe_in(int_oe_out), .button_n_out(button_input_n_in), .pulses_out(pulses),
    .width_out(width));
  initial
  begin
    core_clk_in = 1'b0;
    forever #4 core_clk_in = ~core_clk_in;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk_in);
    #1;
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // Bounded wait; a spent limit ends the run
  task automatic wait_hi(ref logic sig, input int lim);
    for (int i = 0; i < lim && sig !== 1'b1; i++)
      tick(1);
    if (sig !== 1'b1)
    begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, sig, 1'b1);
      end_sim();
    end
  endtask
  // Host write of the rail source code
  task automatic write_src(input logic [1:0] c);
    @(posedge core_clk_in);
    rail_source_select_in <= c;
    rail_source_write_in  <= 1'b1;
    @(posedge core_clk_in);
    rail_source_write_in  <= 1'b0;
    tick(4);
  endtask
  task automatic read_flags();
    @(posedge core_clk_in);
    flag_read_in <= 1'b1;
    @(posedge core_clk_in);
    flag_read_in <= 1'b0;
    tick(3);
    `CHK({first_press_flag_out, second_press_flag_out}, 2'b00)
  endtask
  initial
  begin
    {input_valid_in, input_ovp_in, rail_source_write_in, reset_needs_input_power_in} = '0;
    {hardware_reset_request_in, ship_mode_request_in, adapter_watchdog_enable_in} = '0;
    {i2c_transaction_in, flag_read_in, startup_fault_in, press_req} = '0;
    {input_uvlo_ok_in, input_above_sleep_in, battery_above_uvlo_in, startup_valid_in} = '1;
    {reset_in, rail_source_select_in, long_press_action_in, press_int_mask_in} = 8'h90;
    {first_press_time_in, second_press_time_in} = 16'h0202;
    {long_press_time_in, warning_lead_time_in} = 16'h4004;
    fail_count = 0;
    num_checks = 0;
    void'($urandom(32'h0779));
    repeat (12) @(posedge core_clk_in);
    reset_in <= 1'b0;
    tick(2);
    `CHK({rail_mode_out, rail_pulldown_out, always_on_enable_out}, 4'h1)
    $display("test reset done");
    // Random codes against the reference source model
    for (int k = 0; k < 12; k++)
    begin
      code = $urandom % 4;
      @(posedge core_clk_in);
      battery_above_uvlo_in <= ($urandom % 3) != 0;
      input_valid_in <= $urandom % 2;
      write_src(code[1:0]);
      exp = (code == 1 && !battery_above_uvlo_in) ? 0 : code;
      `CHK(rail_mode_out, exp[1:0])
      `CHK(charge_inhibit_out, exp == 1)
      if (exp < 2)
        `CHK({rail_from_input_out, rail_from_battery_out, regulation_enable_out},
             (exp == 0 && input_valid_in) ? 3'b101 : 3'b010)
      if (exp >= 2)
        `CHK({rail_from_input_out, rail_from_battery_out, rail_pulldown_out,
              aux_regulator_allow_out}, {3'b000, exp == 3} << 1)
      if (exp == 2)
        `CHK(rail_pulldown_out, 1'b0)
    end
    battery_above_uvlo_in <= 1'b1;
    write_src(2'h1);
    battery_above_uvlo_in <= 1'b0;
    tick(4);
    `CHK(rail_mode_out, 2'h0)
    write_src(2'h3);
    input_valid_in <= ~input_valid_in;
    battery_above_uvlo_in <= 1'b1;
    tick(6);
    `CHK(rail_mode_out, 2'h3)
    write_src(2'h0);
    $display("test rail source done");
    // Short presses, unmasked then masked
    p0 = pulses;
    press_req <= 1'b1;
    wait_hi(first_press_flag_out, 200);
    wait_hi(second_press_flag_out, 200);
    press_req <= 1'b0;
    tick(30);
    `CHK(pulses - p0, 2)
    `CHK(width, 8)
    read_flags();
    press_int_mask_in <= 3'h7;
    press_req <= 1'b1;
    wait_hi(first_press_flag_out, 200);
    press_req <= 1'b0;
    press_int_mask_in <= 3'h0;
    tick(30);
    `CHK(pulses - p0, 2)
    read_flags();
    $display("test button done");
    // Ship entry, then valid input ends it at once
    input_valid_in <= 1'b0;
    ship_mode_request_in <= 1'b1;
    tick(1);
    ship_mode_request_in <= 1'b0;
    tick(3);
    `CHK(ship_mode_out, 1'b1)
    input_valid_in <= 1'b1;
    tick(3);
    `CHK(ship_mode_out, 1'b0)
    // Button wake: early release falls back, a long hold wakes
    input_valid_in <= 1'b0;
    ship_mode_request_in <= 1'b1;
    tick(1);
    ship_mode_request_in <= 1'b0;
    press_req <= 1'b1;
    tick(3);
    `CHK({ship_mode_out, always_on_enable_out, rail_pulldown_out}, 3'b011)
    press_req <= 1'b0;
    tick(3);
    `CHK({ship_mode_out, rail_from_battery_out}, 2'b10)
    press_req <= 1'b1;
    tick(40);
    `CHK({ship_mode_out, rail_from_battery_out, second_press_flag_out}, 3'h2)
    `CHK(pulses - p0, 2)
    press_req <= 1'b0;
    tick(2);
    // Late change to power cycle keeps the latched action
    {long_press_time_in, long_press_action_in} <= 10'h031;
    press_req <= 1'b1;
    tick(8);
    long_press_action_in <= 2'h0;
    wait_hi(reset_warning_flag_out, 80);
    tick(24);
    `CHK(hardware_reset_request_active_out, 1'b0)
    press_req <= 1'b0;
    tick(2);
    $display("test ship done");
    // Host power cycle keeps the always-on supply
    hardware_reset_request_in <= 1'b1;
    tick(1);
    hardware_reset_request_in <= 1'b0;
    wait_hi(hardware_reset_request_active_out, 4);
    tick(1);
    `CHK({rail_pulldown_out, always_on_enable_out}, 2'b11)
    tick(20);
    `CHK(hardware_reset_request_active_out, 1'b0)
    // Watchdog from a fresh adapter connection
    input_valid_in <= 1'b0;
    adapter_watchdog_enable_in <= 1'b1;
    tick(2);
    input_valid_in <= 1'b1;
    tick(80);
    i2c_transaction_in <= 1'b1;
    tick(1);
    i2c_transaction_in <= 1'b0;
    tick(60);
    `CHK(hardware_reset_request_active_out, 1'b0)
    input_valid_in <= 1'b0;
    tick(2);
    input_valid_in <= 1'b1;
    tick(80);
    `CHK(hardware_reset_request_active_out, 1'b0)
    wait_hi(hardware_reset_request_active_out, 40);
    $display("test reset sources done");
    end_sim();
  end
endmodule
`default_nettype wire
